// ---- core/sio_defines.vh ----
`ifndef SIO_DEFINES_VH
`define SIO_DEFINES_VH

// Register byte offsets
`define SIO_A_CTRL   8'h00
`define SIO_A_OFFDLY 8'h04
`define SIO_A_POL    8'h08
`define SIO_A_DEB    8'h0c
`define SIO_A_TRQ12  8'h10
`define SIO_A_TRQ34  8'h14
`define SIO_A_SPDLIM 8'h18
`define SIO_A_MBCFG  8'h1c
`define SIO_A_DOUT   8'h20
`define SIO_A_STAT   8'h24
`define SIO_A_PCNT   8'h28
`define SIO_A_IRQST  8'h2c
`define SIO_A_IRQMSK 8'h30
`define SIO_A_RXDAT  8'h34

// Control register fields
`define SIO_C_FORCE   0
`define SIO_C_EDGE    1
`define SIO_C_ENC     2
`define SIO_C_ERRSTOP 3
`define SIO_C_TSRC    4
`define SIO_C_SRST    6
`define SIO_C_ACLR    7
`define SIO_C_MODE    9:8
`define SIO_MODE_TRQ  2'h2

// Serial configuration fields
`define SIO_M_ID   7:0
`define SIO_M_BAUD 18:8
`define SIO_M_FMT  21:20
`define SIO_FMT_N2 2'h0
`define SIO_FMT_O1 2'h2

// Interrupt status bits
`define SIO_I_COMERR 0
`define SIO_I_RXBYTE 1
`define SIO_I_CUTOFF 2
`define SIO_I_DICHG  3

// Reset values
`define SIO_RST_DLY  15'h0000
`define SIO_RST_POL  4'h0
`define SIO_RST_DEB  10'h002
`define SIO_RST_SPD  13'h0bb8
`define SIO_RST_ID   8'h01
`define SIO_RST_BAUD 11'h060
`define SIO_SPD_MAX  13'h1388

// Timing
`define SIO_CLK_NS    50
`define SIO_CLK_HZ    20000000
`define SIO_STEP_NS   100000
`define SIO_STEP_CYC  ((`SIO_STEP_NS + `SIO_CLK_NS - 1) / `SIO_CLK_NS)
`define SIO_BAUD_UNIT 100
`define SIO_OVS       16
`define SIO_GAP_OVS   (35 * 11 * `SIO_OVS / 10)

`endif

// ---- core/sio_debounce.v ----
module sio_debounce (
  input  wire       clk_in,   // System clock
  input  wire       nrst_in,  // Async reset, active low
  input  wire       clr_in,   // Soft restart
  input  wire       step_in,  // 0.1 ms step pulse
  input  wire [9:0] time_in,  // Stable time in steps
  input  wire       raw_in,   // Synchronised terminal level
  output reg        level_out // Accepted level
);

  reg  [9:0] cnt_q;
  wire [9:0] cnt_nx = cnt_q + 10'h001;

  // Needs time_in whole steps of stability, so one extra step edge
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q     <= 10'h000;
      level_out <= 1'b0;
    end else if (clr_in) begin
      cnt_q     <= 10'h000;
      level_out <= 1'b0;
    end else if (raw_in == level_out) begin
      cnt_q <= 10'h000;
    end else if (step_in) begin
      if (cnt_nx > time_in) begin
        level_out <= raw_in;
        cnt_q     <= 10'h000;
      end else begin
        cnt_q <= cnt_nx;
      end
    end
  end

endmodule

// ---- core/sio_param_logic.v ----
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`include "sio_defines.vh"

module sio_param_logic (
  input  wire        clk_in,                // 20 MHz system clock
  input  wire        nrst_in,               // Async reset, active low
  input  wire        hsel_in,               // AHB slave select
  input  wire [31:0] haddr_in,              // AHB address
  input  wire [1:0]  htrans_in,             // AHB transfer type
  input  wire        hwrite_in,             // AHB write
  input  wire [2:0]  hsize_in,              // AHB size, word only
  input  wire [31:0] hwdata_in,             // AHB write data
  input  wire        hready_in,             // AHB bus ready
  output wire        hreadyout_out,         // AHB slave ready
  output wire        hresp_out,             // AHB response, OKAY
  output wire [31:0] hrdata_out,            // AHB read data
  input  wire        input_terminal_one_in,   // Servo-on terminal
  input  wire        input_terminal_two_in,   // Torque select low
  input  wire        input_terminal_three_in, // Torque select high
  input  wire        input_terminal_four_in,  // General terminal
  input  wire        pulse_in,              // Command pulse pin
  input  wire        rx_in,                 // Serial receive pin
  input  wire        enc_a_in,              // Encoder A
  input  wire        enc_b_in,              // Encoder B
  input  wire        enc_z_in,              // Encoder Z
  input  wire        enc_u_in,              // Encoder U
  input  wire        enc_v_in,              // Encoder V
  input  wire        enc_w_in,              // Encoder W
  input  wire [12:0] motor_speed_in,        // Measured speed, rpm
  output reg         output_terminal_one_out,   // Output terminal one
  output reg         output_terminal_two_out,   // Output terminal two
  output reg         output_terminal_three_out, // Output terminal three
  output reg         output_terminal_four_out,  // Output terminal four
  output reg         servo_enable_out,      // Servo enabled
  output reg         current_on_out,        // Motor current allowed
  output reg         alarm_out,             // Latched alarm
  output reg  [15:0] torque_cmd_out,        // Selected torque command
  output reg  [12:0] speed_limit_out,       // Active speed limit
  output reg         overspeed_out,         // Speed above limit, torque mode only
  output reg  [2:0]  enc_abz_out,           // Synchronised A,B,Z
  output reg  [2:0]  enc_uvw_out,           // Commutation U,V,W
  output reg         enc_uvw_valid_out,     // Commutation in use
  output reg         irq_out                // Interrupt, active high
);

  localparam integer STEP_I = `SIO_STEP_CYC - 1;
  localparam [10:0]  STEP_LAST = STEP_I[10:0];
  localparam integer MUL_I = `SIO_BAUD_UNIT * `SIO_OVS;
  localparam [24:0]  OVS_MUL = MUL_I[24:0];
  localparam integer CLK_I = `SIO_CLK_HZ;
  localparam [24:0]  CLK_W = CLK_I[24:0];
  localparam integer GAP_I = `SIO_GAP_OVS;
  localparam [9:0]   GAP_LAST = GAP_I[9:0];

  localparam [4:0] RX_IDLE  = 5'h01;
  localparam [4:0] RX_START = 5'h02;
  localparam [4:0] RX_DATA  = 5'h04;
  localparam [4:0] RX_PAR   = 5'h08;
  localparam [4:0] RX_STOP  = 5'h10;

  // Bus slave
  reg        wr_q;
  reg        rd_q;
  reg [7:0]  addr_q;
  reg        hready_q;
  reg [31:0] hrdata_q;
  reg [31:0] rd_mux;
  wire       acc_ok = hsel_in & htrans_in[1] & hready_in;

  assign hreadyout_out = hready_q;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_q;

  // Parameters held by software
  reg [9:0]  ctrl_q;
  reg [14:0] dly_q;
  reg [3:0]  ipol_q;
  reg [3:0]  opol_q;
  reg [9:0]  deb_q;
  reg [15:0] trq_q [0:3];
  reg [12:0] spd_q;
  reg [7:0]  id_q;
  reg [10:0] baud_q;
  reg [1:0]  fmt_q;
  reg [3:0]  dout_q;
  reg [3:0]  msk_q;
  reg        srst_q;
  reg        aclr_q;

  // Block state
  reg [11:0] pin_s1_q;
  reg [11:0] pin_s2_q;
  reg        pulse_s3_q;
  reg [10:0] step_cnt_q;
  reg        step_q;
  reg [24:0] acc_q;
  reg        ovs_q;
  reg [31:0] pcnt_q;
  reg [14:0] dly_cnt_q;
  reg [3:0]  di_prev_q;
  reg [3:0]  st_q;
  reg [4:0]  rx_st_q;
  reg [3:0]  ovs_cnt_q;
  reg [2:0]  bit_cnt_q;
  reg [7:0]  shift_q;
  reg        perr_q;
  reg [9:0]  gap_q;
  reg        frame_new_q;
  reg        match_q;
  reg [7:0]  rx_data_q;
  reg        byte_ev_q;
  reg        err_ev_q;
  reg        cut_ev_q;

  wire [3:0] di_deb;
  wire [3:0] di_log = di_deb ^ ipol_q;
  wire       rx_s = pin_s2_q[10];
  wire       trq_mode = (ctrl_q[`SIO_C_MODE] == `SIO_MODE_TRQ);
  wire       en_req = ctrl_q[`SIO_C_FORCE] | di_log[0];
  wire       cut_now = (dly_q == 15'h0000) | (dly_cnt_q > dly_q);
  wire       id_hit = frame_new_q ? (shift_q == id_q) : match_q;
  wire [24:0] acc_sum = acc_q + ({14'h0000, baud_q} * OVS_MUL);
  wire       pedge = ctrl_q[`SIO_C_EDGE] ? (pulse_s3_q & ~pin_s2_q[11])
                                         : (~pulse_s3_q & pin_s2_q[11]);
  wire [3:0] w1c = (wr_q && addr_q == `SIO_A_IRQST) ? hwdata_in[3:0]
                                                    : 4'h0;
  wire [3:0] ev = {di_log != di_prev_q, cut_ev_q, byte_ev_q, err_ev_q};
  wire [3:0] st_d = (st_q & ~w1c) | ev;
  wire       alarm_d = (err_ev_q & ctrl_q[`SIO_C_ERRSTOP])
                       | (alarm_out & ~aclr_q);

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      addr_q   <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= 1'b0;
      if (rd_q) begin
        rd_q     <= 1'b0;
        hrdata_q <= rd_mux;
        hready_q <= 1'b1;
      end else if (acc_ok) begin
        addr_q   <= haddr_in[7:0];
        wr_q     <= hwrite_in;
        rd_q     <= ~hwrite_in;
        hready_q <= hwrite_in;
      end
    end
  end

  always @* begin
    case (addr_q)
      `SIO_A_CTRL:   rd_mux = {22'h0, ctrl_q[9:8], 2'h0, ctrl_q[5:0]};
      `SIO_A_OFFDLY: rd_mux = {17'h0, dly_q};
      `SIO_A_POL:    rd_mux = {24'h0, opol_q, ipol_q};
      `SIO_A_DEB:    rd_mux = {22'h0, deb_q};
      `SIO_A_TRQ12:  rd_mux = {trq_q[1], trq_q[0]};
      `SIO_A_TRQ34:  rd_mux = {trq_q[3], trq_q[2]};
      `SIO_A_SPDLIM: rd_mux = {19'h0, spd_q};
      `SIO_A_MBCFG:  rd_mux = {10'h0, fmt_q, 1'b0, baud_q, id_q};
      `SIO_A_DOUT:   rd_mux = {28'h0, dout_q};
      `SIO_A_STAT:   rd_mux = {23'h0, match_q, overspeed_out, alarm_out,
                               current_on_out, servo_enable_out, di_log};
      `SIO_A_PCNT:   rd_mux = pcnt_q;
      `SIO_A_IRQST:  rd_mux = {28'h0, st_q};
      `SIO_A_IRQMSK: rd_mux = {28'h0, msk_q};
      `SIO_A_RXDAT:  rd_mux = {24'h0, rx_data_q};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Register writes land in the data phase
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q   <= 10'h000;
      dly_q    <= `SIO_RST_DLY;
      ipol_q   <= `SIO_RST_POL;
      opol_q   <= `SIO_RST_POL;
      deb_q    <= `SIO_RST_DEB;
      trq_q[0] <= 16'h0000;
      trq_q[1] <= 16'h0000;
      trq_q[2] <= 16'h0000;
      trq_q[3] <= 16'h0000;
      spd_q    <= `SIO_RST_SPD;
      id_q     <= `SIO_RST_ID;
      baud_q   <= `SIO_RST_BAUD;
      fmt_q    <= `SIO_FMT_N2;
      dout_q   <= 4'h0;
      msk_q    <= 4'h0;
      srst_q   <= 1'b0;
      aclr_q   <= 1'b0;
    end else begin
      srst_q <= 1'b0;
      aclr_q <= 1'b0;
      if (wr_q) begin
        case (addr_q)
          `SIO_A_CTRL: begin
            ctrl_q <= {hwdata_in[9:8], 2'h0, hwdata_in[5:0]};
            srst_q <= hwdata_in[`SIO_C_SRST];
            aclr_q <= hwdata_in[`SIO_C_ACLR];
          end
          `SIO_A_OFFDLY: dly_q <= hwdata_in[14:0];
          `SIO_A_POL: begin
            ipol_q <= hwdata_in[3:0];
            opol_q <= hwdata_in[7:4];
          end
          `SIO_A_DEB:    deb_q <= hwdata_in[9:0];
          `SIO_A_TRQ12: begin
            trq_q[0] <= hwdata_in[15:0];
            trq_q[1] <= hwdata_in[31:16];
          end
          `SIO_A_TRQ34: begin
            trq_q[2] <= hwdata_in[15:0];
            trq_q[3] <= hwdata_in[31:16];
          end
          `SIO_A_SPDLIM: spd_q <= hwdata_in[12:0];
          `SIO_A_MBCFG: begin
            id_q   <= hwdata_in[`SIO_M_ID];
            baud_q <= hwdata_in[`SIO_M_BAUD];
            fmt_q  <= hwdata_in[`SIO_M_FMT];
          end
          `SIO_A_DOUT:   dout_q <= hwdata_in[3:0];
          `SIO_A_IRQMSK: msk_q <= hwdata_in[3:0];
          default: ;
        endcase
      end
    end
  end

  // Pin synchronisers, step divider and baud oversampling tick
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_q   <= 12'h400;
      pin_s2_q   <= 12'h400;
      pulse_s3_q <= 1'b0;
      step_cnt_q <= 11'h000;
      step_q     <= 1'b0;
      acc_q      <= 25'h0000000;
      ovs_q      <= 1'b0;
    end else begin
      pin_s1_q   <= {pulse_in, rx_in, input_terminal_four_in,
                     input_terminal_three_in, input_terminal_two_in,
                     input_terminal_one_in, enc_a_in, enc_b_in, enc_z_in,
                     enc_u_in, enc_v_in, enc_w_in};
      pin_s2_q   <= pin_s1_q;
      pulse_s3_q <= pin_s2_q[11];
      step_q     <= (step_cnt_q == STEP_LAST);
      step_cnt_q <= (step_cnt_q == STEP_LAST) ? 11'h000
                                              : step_cnt_q + 11'h001;
      if (acc_sum >= CLK_W) begin
        acc_q <= acc_sum - CLK_W;
        ovs_q <= 1'b1;
      end else begin
        acc_q <= acc_sum;
        ovs_q <= 1'b0;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_deb
      sio_debounce u_deb (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .clr_in    (srst_q),
        .step_in   (step_q),
        .time_in   (deb_q),
        .raw_in    (pin_s2_q[6 + gi]),
        .level_out (di_deb[gi])
      );
    end
  endgenerate

  // Servo enable, delayed current cut-off, alarm, pulses, interrupts
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      servo_enable_out <= 1'b0;
      current_on_out   <= 1'b0;
      dly_cnt_q        <= 15'h0000;
      cut_ev_q         <= 1'b0;
      alarm_out        <= 1'b0;
      pcnt_q           <= 32'h0000_0000;
      di_prev_q        <= 4'h0;
      st_q             <= 4'h0;
      irq_out          <= 1'b0;
    end else if (srst_q) begin
      servo_enable_out <= 1'b0;
      current_on_out   <= 1'b0;
      dly_cnt_q        <= 15'h0000;
      cut_ev_q         <= 1'b0;
      alarm_out        <= 1'b0;
      pcnt_q           <= 32'h0000_0000;
      di_prev_q        <= 4'h0;
      st_q             <= 4'h0;
      irq_out          <= 1'b0;
    end else begin
      cut_ev_q         <= 1'b0;
      alarm_out        <= alarm_d;
      servo_enable_out <= en_req & ~alarm_out;
      if (servo_enable_out) begin
        current_on_out <= 1'b1;
        dly_cnt_q      <= 15'h0000;
      end else if (current_on_out) begin
        if (alarm_out | cut_now) begin
          current_on_out <= 1'b0;
          cut_ev_q       <= 1'b1;
        end else if (step_q) begin
          dly_cnt_q <= dly_cnt_q + 15'h0001;
        end
      end
      if (pedge) begin
        pcnt_q <= pcnt_q + 32'h0000_0001;
      end
      di_prev_q <= di_log;
      st_q      <= st_d;
      irq_out   <= |(st_d & msk_q);
    end
  end

  // Serial receiver with frame gap and slave id filter
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_st_q     <= RX_IDLE;
      ovs_cnt_q   <= 4'h0;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 8'h00;
      perr_q      <= 1'b0;
      gap_q       <= 10'h000;
      frame_new_q <= 1'b0;
      match_q     <= 1'b0;
      rx_data_q   <= 8'h00;
      byte_ev_q   <= 1'b0;
      err_ev_q    <= 1'b0;
    end else if (srst_q) begin
      rx_st_q     <= RX_IDLE;
      gap_q       <= 10'h000;
      frame_new_q <= 1'b0;
      match_q     <= 1'b0;
      byte_ev_q   <= 1'b0;
      err_ev_q    <= 1'b0;
    end else begin
      byte_ev_q <= 1'b0;
      err_ev_q  <= 1'b0;
      if (ovs_q) begin
        case (rx_st_q)
          RX_IDLE: begin
            ovs_cnt_q <= 4'h0;
            if (!rx_s) begin
              rx_st_q <= RX_START;
            end else if (gap_q == GAP_LAST) begin
              frame_new_q <= 1'b1;
            end else begin
              gap_q <= gap_q + 10'h001;
            end
          end
          RX_START: begin
            ovs_cnt_q <= ovs_cnt_q + 4'h1;
            if (ovs_cnt_q == 4'h7) begin
              ovs_cnt_q <= 4'h0;
              bit_cnt_q <= 3'h0;
              perr_q    <= 1'b0;
              rx_st_q   <= rx_s ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            ovs_cnt_q <= ovs_cnt_q + 4'h1;
            if (ovs_cnt_q == 4'hf) begin
              shift_q   <= {rx_s, shift_q[7:1]};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == 3'h7) begin
                rx_st_q <= (fmt_q == `SIO_FMT_N2) ? RX_STOP : RX_PAR;
              end
            end
          end
          RX_PAR: begin
            ovs_cnt_q <= ovs_cnt_q + 4'h1;
            if (ovs_cnt_q == 4'hf) begin
              perr_q  <= ^{shift_q, rx_s} ^ (fmt_q == `SIO_FMT_O1);
              rx_st_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            ovs_cnt_q <= ovs_cnt_q + 4'h1;
            if (ovs_cnt_q == 4'hf) begin
              rx_st_q     <= RX_IDLE;
              gap_q       <= 10'h000;
              frame_new_q <= 1'b0;
              if (!rx_s | perr_q) begin
                err_ev_q <= 1'b1;
                match_q  <= 1'b0;
              end else begin
                match_q <= id_hit;
                if (id_hit) begin
                  rx_data_q <= shift_q;
                  byte_ev_q <= 1'b1;
                end
              end
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Torque select, speed limit, encoder and output terminals
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      torque_cmd_out    <= 16'h0000;
      speed_limit_out   <= `SIO_SPD_MAX;
      overspeed_out     <= 1'b0;
      enc_abz_out       <= 3'h0;
      enc_uvw_out       <= 3'h0;
      enc_uvw_valid_out <= 1'b0;
      output_terminal_one_out   <= 1'b0;
      output_terminal_two_out   <= 1'b0;
      output_terminal_three_out <= 1'b0;
      output_terminal_four_out  <= 1'b0;
    end else begin
      if (trq_mode & ctrl_q[`SIO_C_TSRC]) begin
        torque_cmd_out <= trq_q[{di_log[2], di_log[1]}];
      end else begin
        torque_cmd_out <= 16'h0000;
      end
      speed_limit_out <= trq_mode ? spd_q : `SIO_SPD_MAX;
      overspeed_out   <= trq_mode & (motor_speed_in > spd_q);
      enc_abz_out     <= pin_s2_q[5:3];
      enc_uvw_out     <= ctrl_q[`SIO_C_ENC] ? 3'h0 : pin_s2_q[2:0];
      enc_uvw_valid_out <= ~ctrl_q[`SIO_C_ENC];
      output_terminal_one_out   <= dout_q[0] ^ opol_q[0];
      output_terminal_two_out   <= dout_q[1] ^ opol_q[1];
      output_terminal_three_out <= dout_q[2] ^ opol_q[2];
      output_terminal_four_out  <= dout_q[3] ^ opol_q[3];
    end
  end

endmodule

// ---- dv/sio_param_monitor.sv ----
module sio_param_monitor (
  input logic        clk_in,            // Clock
  input logic        nrst_in,           // Reset, active low
  input logic        hsel_in,           // Select
  input logic [1:0]  htrans_in,         // Transfer type
  input logic        hwrite_in,         // Write
  input logic        hready_in,         // Bus ready
  input logic        hreadyout_out,     // Slave ready
  input logic        hresp_out,         // Response
  input logic [31:0] hrdata_out,        // Read data
  input logic        enc_z_in,          // Encoder Z pin
  input logic [2:0]  enc_abz_out,       // Synced A,B,Z
  input logic [2:0]  enc_uvw_out,       // Commutation
  input logic        enc_uvw_valid_out, // Commutation in use
  input logic        servo_enable_out,  // Servo enabled
  input logic        current_on_out,    // Current allowed
  input logic        alarm_out          // Latched alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_req;
  logic wr_req;
  assign rd_req = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
  assign wr_req = hsel_in && htrans_in[1] && hready_in && hwrite_in;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  bus_okay_a: assert property (hresp_out == 1'b0)
    else $error("response not OKAY");
  read_wait_a: assert property (rd_req |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  write_nowait_a: assert property (wr_req |=> hreadyout_out)
    else $error("write stalled");
  rdata_hold_a: assert property (!$stable(hrdata_out) |-> $rose(hreadyout_out))
    else $error("read data moved outside a read");
  abz_follow_a: assert property (enc_z_in [*5] |-> enc_abz_out[0])
    else $error("encoder Z not followed");
  uvw_off_a: assert property (
      !enc_uvw_valid_out |-> enc_uvw_out == 3'h0)
    else $error("commutation shown while unused");
  alarm_stop_a: assert property (alarm_out |=> !servo_enable_out)
    else $error("servo enabled under alarm");
  current_src_a: assert property ($rose(current_on_out) |->
      servo_enable_out || $past(servo_enable_out))
    else $error("current without servo enable");
endmodule

bind sio_param_logic sio_param_monitor u_mon (
  .clk_in, .nrst_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in,
  .hreadyout_out, .hresp_out, .hrdata_out, .enc_z_in, .enc_abz_out,
  .enc_uvw_out, .enc_uvw_valid_out, .servo_enable_out, .current_on_out,
  .alarm_out
);

// ---- dv/sio_host_model.sv ----
module sio_host_model #(
  parameter int BIT_CYC = 174 // 115200 baud at 20 MHz
) (
  input  logic clk_in, // Clock
  output logic rx_out  // Serial line, idle high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_out = 1'b1;
  // One character of eleven bit times, LSB first
  task automatic send(input logic [7:0] b, input logic [1:0] fmt,
                      input logic bad);
    logic [10:0] f;
    f = {1'b1, (fmt == 2'h0) ? ~bad : ^{b, fmt[1], bad}, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_out <= f[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
  endtask
endmodule

// ---- dv/sio_param_logic_tb.sv ----
module sio_param_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        hsel_in = 1'b0;
  logic        hwrite_in = 1'b0;
  logic [1:0]  htrans_in = 2'h0;
  logic [31:0] haddr_in = 32'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic [3:0]  di = 4'h0;
  logic        pulse_in = 1'b0;
  logic [5:0]  enc = 6'h0;
  logic [12:0] motor_speed_in = 13'h0;
  logic [15:0] tq [4] = '{16'h012c, 16'hff9c, 16'h0064, 16'hfed4};
  int          failures = 0;
  int          cmp_count = 0;
  int          n;
  wire         hready_in, hreadyout_out, rx_in;
  wire [31:0]  hrdata_out;
  wire [15:0]  torque_cmd_out;
  wire [12:0]  speed_limit_out;
  wire [2:0]   enc_abz_out, enc_uvw_out;
  wire         servo_enable_out, current_on_out, alarm_out, irq_out;
  wire         overspeed_out, enc_uvw_valid_out;
  wire         output_terminal_one_out, output_terminal_two_out;
  wire         output_terminal_three_out, output_terminal_four_out;
  wire [3:0]   dout;
  assign dout = {output_terminal_four_out, output_terminal_three_out,
                 output_terminal_two_out, output_terminal_one_out};
  assign hready_in = hreadyout_out;
  always #25 clk_in = ~clk_in;

  sio_param_logic dut (
    .clk_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in(3'h2), .hwdata_in, .hready_in, .hreadyout_out,
    .hresp_out(), .hrdata_out,
    .input_terminal_one_in(di[0]), .input_terminal_two_in(di[1]),
    .input_terminal_three_in(di[2]), .input_terminal_four_in(di[3]),
    .pulse_in, .rx_in, .enc_a_in(enc[5]), .enc_b_in(enc[4]),
    .enc_z_in(enc[3]), .enc_u_in(enc[2]), .enc_v_in(enc[1]),
    .enc_w_in(enc[0]), .motor_speed_in, .output_terminal_one_out,
    .output_terminal_two_out, .output_terminal_three_out,
    .output_terminal_four_out, .servo_enable_out, .current_on_out,
    .alarm_out, .torque_cmd_out, .speed_limit_out, .overspeed_out,
    .enc_abz_out, .enc_uvw_out, .enc_uvw_valid_out, .irq_out
  );
  sio_host_model host (.clk_in, .rx_out(rx_in));

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  // One single word transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= {24'h0, a};
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    r = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  initial begin
    cyc(100000);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    cyc(5);
    nrst_in <= 1'b1;
    cyc(1);
    rd(8'h0c, 32'h2);
    rd(8'h18, 32'hbb8);
    rd(8'h1c, 32'h6001);
    rd(8'h3c, 32'h0);
    chk({19'h0, speed_limit_out}, 32'h1388);
    wr(8'h0c, 32'h1);
    wr(8'h20, 32'h5);
    wr(8'h08, 32'hf1);
    cyc(4);
    chk({28'h0, dout}, 32'ha);
    chkb(servo_enable_out, 1'b1);
    chkb(irq_out, 1'b0);
    rd(8'h24, 32'h31);
    di[0] <= 1'b1;
    cyc(1900);
    chkb(servo_enable_out, 1'b1);
    cyc(2110);
    chkb(servo_enable_out, 1'b0);
    chkb(current_on_out, 1'b0);
    wr(8'h04, 32'h3);
    di[0] <= 1'b0;
    cyc(4010);
    di[0] <= 1'b1;
    n = 0;
    while (servo_enable_out !== 1'b0 && n < 4100) begin
      cyc(1);
      n++;
    end
    cyc(5900);
    chkb(current_on_out, 1'b1);
    cyc(2200);
    chkb(current_on_out, 1'b0);
    wr(8'h00, 32'h1);
    cyc(3);
    chkb(servo_enable_out, 1'b1);
    wr(8'h10, 32'hff9c012c);
    wr(8'h14, 32'hfed40064);
    wr(8'h00, 32'h210);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {28'h0, 1'b0, i[1:0], 1'b0});
      cyc(3);
      chk({16'h0, torque_cmd_out}, {16'h0, tq[i]});
    end
    wr(8'h18, 32'h3e8);
    motor_speed_in <= 13'h3e9;
    cyc(3);
    chk({19'h0, speed_limit_out}, 32'h3e8);
    chkb(overspeed_out, 1'b1);
    motor_speed_in <= 13'h3e8;
    cyc(3);
    chkb(overspeed_out, 1'b0);
    for (int i = 0; i < 6; i++) begin
      pulse_in <= ~pulse_in;
      cyc(8);
    end
    rd(8'h28, 32'h3);
    wr(8'h00, 32'h2);
    pulse_in <= 1'b1;
    cyc(8);
    rd(8'h28, 32'h3);
    pulse_in <= 1'b0;
    cyc(8);
    rd(8'h28, 32'h4);
    enc <= 6'h3f;
    wr(8'h00, 32'h4);
    cyc(5);
    chk({28'h0, enc_uvw_valid_out, enc_uvw_out}, 32'h0);
    wr(8'h00, 32'h0);
    cyc(4);
    chk({25'h0, enc_uvw_valid_out, enc_abz_out, enc_uvw_out},
        32'h7f);
    wr(8'h2c, 32'hf);
    wr(8'h30, 32'h2);
    for (int f = 0; f < 3; f++) begin
      wr(8'h1c, {10'h0, f[1:0], 1'b0, 11'h480, 8'h05});
      cyc(7000);
      host.send(8'h05, f[1:0], 1'b0);
      host.send({6'h0c, f[1:0]}, f[1:0], 1'b0);
      cyc(10);
      rd(8'h34, {24'h0, 6'h0c, f[1:0]});
      chkb(irq_out, 1'b1);
      wr(8'h2c, 32'h2);
      cyc(2);
      chkb(irq_out, 1'b0);
    end
    cyc(7000);
    host.send(8'h06, 2'h2, 1'b0);
    host.send(8'h77, 2'h2, 1'b0);
    cyc(10);
    rd(8'h34, 32'h32);
    chkb(irq_out, 1'b0);
    wr(8'h30, 32'h1);
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, {28'h0, e[0], 3'h0});
      cyc(7000);
      host.send(8'h05, 2'h2, 1'b1);
      cyc(10);
      chkb(irq_out, 1'b1);
      chkb(alarm_out, e[0]);
      chkb(servo_enable_out, ~e[0]);
      wr(8'h2c, 32'h1);
    end
    // Alarm cut the current; only that status bit is left
    rd(8'h2c, 32'h4);
    wr(8'h00, 32'h80);
    cyc(3);
    chkb(alarm_out, 1'b0);
    wr(8'h00, 32'h40);
    cyc(3);
    rd(8'h28, 32'h0);
    rd(8'h0c, 32'h1);
    results();
  end
endmodule
